// *** verilog/ievi_pkg.sv ***
/*
  Package for the event flag and interrupt enable block: register offsets,
  bit positions, reset values and the APB request carrier.
  Assumes a 32-bit APB slave with byte addresses on a 12-bit offset.
*/
package ievi_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          ADDR_W             = 12;
  localparam logic [11:0] OFS_START          = 12'h000;
  localparam logic [11:0] OFS_STOP           = 12'h004;
  localparam logic [11:0] OFS_RX_PTR_UPD     = 12'h104;
  localparam logic [11:0] OFS_STOPPED        = 12'h108;
  localparam logic [11:0] OFS_TX_PTR_UPD     = 12'h114;
  localparam logic [11:0] OFS_INT_ENABLE     = 12'h300;
  localparam logic [11:0] OFS_INT_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFS_INT_ENABLE_CLR = 12'h308;
  localparam logic [11:0] OFS_CTRL           = 12'h500;
  localparam logic [11:0] OFS_WORD_COUNT     = 12'h550;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int          BIT_RX_PTR_UPD = 1;
  localparam int          BIT_STOPPED    = 2;
  localparam int          BIT_TX_PTR_UPD = 5;
  localparam int          BIT_CTRL_RXEN  = 0;
  localparam int          BIT_CTRL_TXEN  = 1;
  localparam logic [31:0] RST_EVENT      = 32'h0000_0000;
  localparam logic [31:0] RST_INT_ENABLE = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
  localparam logic [15:0] RST_WORD_COUNT = 16'h0001;
  localparam logic [31:0] INT_MASK       = 32'h0000_0026;
  localparam int          CNT_W          = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write;
    logic [31:0]       wdata;
  } ievi_req_t;

  typedef enum logic [1:0] {
    IEVI_IDLE    = 2'b01,
    IEVI_RUNNING = 2'b10
  } ievi_state_t;

endpackage

// *** verilog/ievi_top.sv ***
/*
  Event flags, interrupt enables and the small transfer-state machine of an
  audio serial interface, reached over APB.
  Assumes the transfer engine pulses word strobes on clk, one per word sent
  or received, and that APB signals come from logic on the same clock.
*/
`timescale 1ns/1ns

module ievi_top (
  input  wire logic                     clk,         // 20 MHz clock
  input  wire logic                     rst_n,       // sync reset, low
  input  wire logic                     clk_en,      // freezes state when low
  input  wire logic                     psel,        // apb select
  input  wire logic                     penable,     // apb access phase
  input  wire logic                     pwrite,      // apb direction
  input  wire logic [ievi_pkg::ADDR_W-1:0] paddr,    // apb byte address
  input  wire logic [31:0]              pwdata,      // apb write data
  output logic      [31:0]              prdata,      // apb read data
  output logic                          pready,      // apb ready
  output logic                          pslverr,     // apb error
  input  wire logic                     tx_word_sent, // word shifted out
  input  wire logic                     rx_word_recv, // word received
  output logic                          running,     // transfer active
  output logic                          irq          // interrupt request
);
  import ievi_pkg::*;

  // ************************************************************
  // apb decode
  // ************************************************************
  ievi_req_t   req;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;
  logic [31:0] wd;

  assign req    = '{addr: paddr, write: pwrite, wdata: pwdata};
  assign wr_acc = psel && penable && req.write && clk_en;
  assign rd_acc = psel && penable && !req.write && clk_en;
  assign wd     = req.wdata;

  always_comb begin
    case (req.addr)
      OFS_START, OFS_STOP, OFS_RX_PTR_UPD, OFS_STOPPED, OFS_TX_PTR_UPD,
      OFS_INT_ENABLE, OFS_INT_ENABLE_SET, OFS_INT_ENABLE_CLR,
      OFS_CTRL, OFS_WORD_COUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // zero wait states; unmapped accesses end with an error
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ************************************************************
  // control registers
  // ************************************************************
  logic [1:0]       ctrl_q;
  logic [CNT_W-1:0] word_count_q;
  logic             start_task;
  logic             stop_task;

  assign start_task = wr_acc && req.addr == OFS_START && wd[0];
  assign stop_task  = wr_acc && req.addr == OFS_STOP && wd[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q       <= RST_CTRL[1:0];
      word_count_q <= RST_WORD_COUNT;
    end else if (wr_acc) begin
      if (req.addr == OFS_CTRL) begin
        ctrl_q <= wd[1:0];
      end
      if (req.addr == OFS_WORD_COUNT) begin
        word_count_q <= wd[CNT_W-1:0];
      end
    end
  end

  // ************************************************************
  // transfer state
  // ************************************************************
  ievi_state_t state_q;
  logic        stopped_ev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= IEVI_IDLE;
    end else if (clk_en) begin
      case (state_q)
        IEVI_IDLE: begin
          if (start_task && !stop_task) begin
            state_q <= IEVI_RUNNING;
          end
        end
        IEVI_RUNNING: begin
          if (stop_task) begin
            state_q <= IEVI_IDLE;
          end
        end
        default: state_q <= IEVI_IDLE;
      endcase
    end
  end

  // stopped is flagged the cycle after the halt takes effect
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stopped_ev <= 1'b0;
    end else if (clk_en) begin
      stopped_ev <= stop_task;
    end
  end

  assign running = (state_q == IEVI_RUNNING);

  // ************************************************************
  // word counters, one per direction
  // ************************************************************
  logic [1:0] word_in;
  logic [1:0] dir_en;
  logic [1:0] ptr_ev;

  assign word_in = {tx_word_sent, rx_word_recv};
  assign dir_en  = {ctrl_q[BIT_CTRL_TXEN], ctrl_q[BIT_CTRL_RXEN]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_dir
      logic [CNT_W-1:0] cnt_q;
      logic             hit;
      // a word count of zero behaves as one, so the event never stalls
      assign hit = (cnt_q + 16'h0001 >= word_count_q);
      assign ptr_ev[gi] = running && dir_en[gi] && word_in[gi] && hit;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          cnt_q <= '0;
        end else if (clk_en) begin
          if (!running || !dir_en[gi]) begin
            cnt_q <= '0;
          end else if (word_in[gi]) begin
            cnt_q <= hit ? '0 : cnt_q + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // ************************************************************
  // event flags
  // ************************************************************
  logic [31:0] flags_q;
  logic [31:0] ev_set;

  always_comb begin
    ev_set                 = '0;
    ev_set[BIT_RX_PTR_UPD] = ptr_ev[0];
    ev_set[BIT_STOPPED]    = stopped_ev;
    ev_set[BIT_TX_PTR_UPD] = ptr_ev[1];
  end

  // each flag is its own register; a write stores bit 0, a new event wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= RST_EVENT;
    end else if (clk_en) begin
      if (wr_acc && req.addr == OFS_RX_PTR_UPD) begin
        flags_q[BIT_RX_PTR_UPD] <= wd[0];
      end
      if (wr_acc && req.addr == OFS_STOPPED) begin
        flags_q[BIT_STOPPED] <= wd[0];
      end
      if (wr_acc && req.addr == OFS_TX_PTR_UPD) begin
        flags_q[BIT_TX_PTR_UPD] <= wd[0];
      end
      flags_q <= (flags_q | ev_set) & INT_MASK;
      if (wr_acc && req.addr == OFS_RX_PTR_UPD) begin
        flags_q[BIT_RX_PTR_UPD] <= wd[0] | ev_set[BIT_RX_PTR_UPD];
      end
      if (wr_acc && req.addr == OFS_STOPPED) begin
        flags_q[BIT_STOPPED] <= wd[0] | ev_set[BIT_STOPPED];
      end
      if (wr_acc && req.addr == OFS_TX_PTR_UPD) begin
        flags_q[BIT_TX_PTR_UPD] <= wd[0] | ev_set[BIT_TX_PTR_UPD];
      end
    end
  end

  // ************************************************************
  // interrupt enables
  // ************************************************************
  logic [31:0] int_en_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      int_en_q <= RST_INT_ENABLE;
    end else if (wr_acc) begin
      case (req.addr)
        OFS_INT_ENABLE:     int_en_q <= wd & INT_MASK;
        OFS_INT_ENABLE_SET: int_en_q <= int_en_q | (wd & INT_MASK);
        OFS_INT_ENABLE_CLR: int_en_q <= int_en_q & ~wd;
        default:            int_en_q <= int_en_q;
      endcase
    end
  end

  // level interrupt straight from the flag and enable registers
  assign irq = |(flags_q & int_en_q);

  // ************************************************************
  // read data
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !req.write && clk_en) begin
      case (req.addr)
        OFS_RX_PTR_UPD:     prdata <= {31'h0, flags_q[BIT_RX_PTR_UPD]};
        OFS_STOPPED:        prdata <= {31'h0, flags_q[BIT_STOPPED]};
        OFS_TX_PTR_UPD:     prdata <= {31'h0, flags_q[BIT_TX_PTR_UPD]};
        OFS_INT_ENABLE,
        OFS_INT_ENABLE_SET,
        OFS_INT_ENABLE_CLR: prdata <= int_en_q;
        OFS_CTRL:           prdata <= {30'h0, ctrl_q};
        OFS_WORD_COUNT:     prdata <= {16'h0, word_count_q};
        default:            prdata <= '0;
      endcase
    end
  end

  logic unused_rd;
  assign unused_rd = rd_acc;

endmodule

// *** tb/ievi_checker.sv ***
/* Assertions on the ports of ievi_top.
   Assumes one clock domain and a bind at the foot of this file. */
`timescale 1ns/1ns
module ievi_checker
  import ievi_pkg::*;
(
  input wire logic              clk,          // clock
  input wire logic              rst_n,        // sync reset
  input wire logic              clk_en,       // state enable
  input wire logic              psel,         // apb select
  input wire logic              penable,      // apb access
  input wire logic              pwrite,       // apb direction
  input wire logic [ADDR_W-1:0] paddr,        // apb address
  input wire logic [31:0]       pwdata,       // apb write data
  input wire logic [31:0]       prdata,       // apb read data
  input wire logic              pready,       // apb ready
  input wire logic              pslverr,      // apb error
  input wire logic              tx_word_sent, // word out
  input wire logic              rx_word_recv, // word in
  input wire logic              running,      // transfer active
  input wire logic              irq           // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ******************************
  // sequences
  // ******************************
  sequence s_wr(logic [11:0] a);
    psel && penable && pwrite && clk_en && paddr == a && pwdata[0];
  endsequence
  sequence s_ensetup;
    psel && !penable && !pwrite && clk_en && paddr == OFS_INT_ENABLE;
  endsequence
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err; psel && penable && paddr == OFS_INT_ENABLE |-> !pslverr;
  endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_unm; psel && penable && paddr == 12'hFFC |-> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("no pslverr");
  property p_rsv; s_ensetup |=> (prdata & ~INT_MASK) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_stop; s_wr(OFS_STOP) |=> !running; endproperty
  a_stop: assert property (p_stop) else $error("still running");
  property p_start; s_wr(OFS_START) |=> running; endproperty
  a_start: assert property (p_start) else $error("not running");
  property p_rise;
    $rose(irq) |-> $past(tx_word_sent || rx_word_recv || psel && pwrite)
      || ($past(running, 2) && !$past(running));
  endproperty
  a_rise: assert property (p_rise) else $error("irq no cause");
  property p_fall; $fell(irq) |-> $past(psel && penable && pwrite);
  endproperty
  a_fall: assert property (p_fall) else $error("irq fell");
  property p_frz; !clk_en |=> $stable(running) && $stable(irq); endproperty
  a_frz: assert property (p_frz) else $error("not frozen");
endmodule
bind ievi_top ievi_checker u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_word_sent(tx_word_sent), .rx_word_recv(rx_word_recv),
  .running(running), .irq(irq));

// *** tb/testbench.sv ***
/* Self-checking bench for ievi_top over APB.
   Assumes zero-wait APB and single-cycle word strobes. */
`timescale 1ns/1ns
module testbench;
  import ievi_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic tx_w = 0, rx_w = 0, pready, pslverr, running, irq;
  logic clk_en = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v, seed = 32'd37680;
  logic [31:0] exp_q[$];
  int errors = 0, total_checks = 0;
  always #25 clk = ~clk;
  ievi_top dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_word_sent(tx_w), .rx_word_recv(rx_w), .running(running), .irq(irq));
  // ******************************
  // helpers
  // ******************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic pulse(input logic tx);
    @(posedge clk);
    tx_w <= tx; rx_w <= !tx;
    @(posedge clk);
    tx_w <= 0; rx_w <= 0;
    repeat (xs() % 3) @(posedge clk);
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk);
    #1 chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // read data taken at the access edge, oldest note first
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready) chk(prdata, exp_q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    summarize();
  end
  // ******************************
  // scenarios
  // ******************************
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    rd(OFS_TX_PTR_UPD, RST_EVENT);
    rd(OFS_INT_ENABLE, RST_INT_ENABLE);
    v = xs();
    apb(OFS_INT_ENABLE, 1, v);
    rd(OFS_INT_ENABLE_SET, v & INT_MASK);
    apb(OFS_INT_ENABLE_CLR, 1, 32'h0);
    rd(OFS_INT_ENABLE_CLR, v & INT_MASK);
    apb(OFS_INT_ENABLE_CLR, 1, 32'h0000_0004);
    rd(OFS_INT_ENABLE, v & 32'h0000_0022);
    rd(12'hFFC, 32'h0);
    apb(OFS_INT_ENABLE, 1, 32'h0000_0020);
    apb(OFS_WORD_COUNT, 1, 32'h3);
    apb(OFS_CTRL, 1, 32'h2);
    apb(OFS_START, 1, 32'h1);
    pulse(1); pulse(1);
    irq_is(0);
    rd(OFS_TX_PTR_UPD, 32'h0);
    pulse(1);
    irq_is(1);
    rd(OFS_TX_PTR_UPD, 32'h1);
    apb(OFS_INT_ENABLE_CLR, 1, 32'h0000_0020);
    irq_is(0);
    apb(OFS_TX_PTR_UPD, 1, 32'h0);
    apb(OFS_CTRL, 1, 32'h1);
    apb(OFS_INT_ENABLE_SET, 1, 32'h0000_0002);
    pulse(0); pulse(0); pulse(0);
    irq_is(1);
    rd(OFS_RX_PTR_UPD, 32'h1);
    apb(OFS_RX_PTR_UPD, 1, 32'h0);
    irq_is(0);
    apb(OFS_INT_ENABLE, 1, 32'h0000_0004);
    apb(OFS_STOP, 1, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk({30'h0, running, irq}, 32'h1);
    rd(OFS_STOPPED, 32'h1);
    // a write while frozen must not land, and irq must hold its level
    clk_en <= 0;
    apb(OFS_INT_ENABLE, 1, 32'h0);
    clk_en <= 1;
    irq_is(1);
    rd(OFS_INT_ENABLE, 32'h0000_0004);
    summarize();
  end
endmodule
